// ==== src/scrcb_apb_slave.v ====
// Purpose: APB slave front end, decodes word index and strobes
// Assumes: zero wait states, 32-bit data
// Notes:   unmapped indices answer with pslverr
`timescale 1ns/10ps
module scrcb_apb_slave #(
  parameter ADDR_W   = 5,
  parameter NUM_REGS = 5
) (
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  output wire              pready,
  output wire              pslverr,
  output wire              wr_stb,
  output wire              rd_acc,
  output wire [2:0]        reg_idx
);

  // ========================================================
  // decode
  localparam [ADDR_W-1:0] REG_COUNT = NUM_REGS;

  wire access = psel & penable;
  wire mapped = ({2'b00, paddr[ADDR_W-1:2]} < REG_COUNT);

  assign reg_idx = paddr[4:2];
  assign pready  = access;
  assign pslverr = access & ~mapped;
  assign wr_stb  = access & pwrite & mapped;
  assign rd_acc  = access & ~pwrite;

endmodule

// ==== src/scrcb_bank.v ====
// Purpose: five-register bank whose last register drives serdes reset,
//          reference oscillator enables and per-quad clock selection
// Assumes: APB slave, sys_clk 25 MHz, synchronous active-high rst
// Notes:   quad 0 decode kept though only quad 1 may be built
`timescale 1ns/10ps
`include "scrcb_regs.vh"
module scrcb_bank (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [4:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  output wire        serdes_rst_n,
  output wire        quad1_local_oscillator_en,
  output wire        quad0_local_oscillator_en,
  output wire        quad1_use_local,
  output wire        quad1_use_external_refclk_zero,
  output wire        quad1_use_external_refclk_one,
  output wire        quad1_local_invalid,
  output wire        quad0_use_local,
  output wire        quad0_use_external_refclk_zero,
  output wire        quad0_use_external_refclk_one,
  output wire        quad0_local_invalid
);

  // ========================================================
  // bus front end
  wire       wr_stb;
  wire       rd_acc;
  wire [2:0] reg_idx;

  scrcb_apb_slave #(
    .ADDR_W   (`SCRCB_ADDR_W),
    .NUM_REGS (`SCRCB_NUM_REGS)
  ) u_apb (
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pready  (pready),
    .pslverr (pslverr),
    .wr_stb  (wr_stb),
    .rd_acc  (rd_acc),
    .reg_idx (reg_idx)
  );

  // byte-lane write mask from pstrb
  wire [31:0] lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                           {8{pstrb[1]}}, {8{pstrb[0]}}};

  // ========================================================
  // general purpose registers
  reg [`SCRCB_GP_W-1:0] gp_r [0:3];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_gp
      always @(posedge sys_clk) begin
        if (rst) begin
          gp_r[gi] <= `SCRCB_GP_RESET;
        end else if (wr_stb && reg_idx == gi) begin
          gp_r[gi] <= (gp_r[gi] & ~lane_mask) | (pwdata & lane_mask);
        end
      end
    end
  endgenerate

  // ========================================================
  // configuration register
  reg  [`SCRCB_CFG_W-1:0] cfg_r;
  wire [`SCRCB_CFG_W-1:0] cfg_nxt;
  wire [`SCRCB_CFG_W-1:0] cfg_mask;

  // reserved positions never store, so they read back as zero
  assign cfg_mask = lane_mask[15:0] & `SCRCB_CFG_WMASK;
  assign cfg_nxt  = (cfg_r & ~cfg_mask) | (pwdata[15:0] & cfg_mask);

  always @(posedge sys_clk) begin
    if (rst) begin
      cfg_r <= `SCRCB_CFG_RESET;
    end else if (wr_stb && reg_idx == `SCRCB_CFG_IDX) begin
      cfg_r <= cfg_nxt;
    end
  end

  // ========================================================
  // read data
  always @(posedge sys_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      // sampled in setup so data is registered when pready rises
      case (paddr[4:2])
        `SCRCB_GP0_IDX: prdata <= gp_r[0];
        `SCRCB_GP1_IDX: prdata <= gp_r[1];
        `SCRCB_GP2_IDX: prdata <= gp_r[2];
        `SCRCB_GP3_IDX: prdata <= gp_r[3];
        `SCRCB_CFG_IDX: prdata <= {16'h0000, cfg_r};
        default:        prdata <= 32'h00000000;
      endcase
    end
  end

  // ========================================================
  // serdes controls
  // active-low serdes reset
  assign serdes_rst_n              = cfg_r[`SCRCB_BIT_RST_N];
  assign quad1_local_oscillator_en = cfg_r[`SCRCB_BIT_OSC1_EN];
  assign quad0_local_oscillator_en = cfg_r[`SCRCB_BIT_OSC0_EN];

  scrcb_quad_sel u_q1 (
    .sel_shared    (cfg_r[`SCRCB_BIT_Q1_SEL]),
    .mux_ctl       (cfg_r[`SCRCB_BIT_Q1_MUX]),
    .osc_en        (cfg_r[`SCRCB_BIT_OSC1_EN]),
    .use_local     (quad1_use_local),
    .use_ext_zero  (quad1_use_external_refclk_zero),
    .use_ext_one   (quad1_use_external_refclk_one),
    .local_invalid (quad1_local_invalid)
  );

  scrcb_quad_sel u_q0 (
    .sel_shared    (cfg_r[`SCRCB_BIT_Q0_SEL]),
    .mux_ctl       (cfg_r[`SCRCB_BIT_Q0_MUX]),
    .osc_en        (cfg_r[`SCRCB_BIT_OSC0_EN]),
    .use_local     (quad0_use_local),
    .use_ext_zero  (quad0_use_external_refclk_zero),
    .use_ext_one   (quad0_use_external_refclk_one),
    .local_invalid (quad0_local_invalid)
  );

endmodule

// ==== src/scrcb_quad_sel.v ====
// Purpose: per-quad reference clock source decode
// Assumes: select inputs come straight from configuration flip-flops
// Notes:   gives selection codes only; the clock muxing is in the hard quad
`timescale 1ns/10ps
module scrcb_quad_sel (
  input  wire sel_shared,
  input  wire mux_ctl,
  input  wire osc_en,
  output wire use_local,
  output wire use_ext_zero,
  output wire use_ext_one,
  output wire local_invalid
);

  // ========================================================
  // decode
  assign use_local     = ~sel_shared;
  // mux control only matters once the shared clock is picked
  assign use_ext_zero  = sel_shared & ~mux_ctl;
  assign use_ext_one   = sel_shared & mux_ctl;
  // local clock without its oscillator running is unusable
  assign local_invalid = ~sel_shared & ~osc_en;

endmodule

// ==== src/scrcb_regs.vh ====
// Purpose: register offsets, field positions and reset values of the
//          serdes reference clock configuration bank
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   none
`ifndef SCRCB_REGS_VH
`define SCRCB_REGS_VH

// ==========================================================
// register indices and address width
`define SCRCB_NUM_REGS        5
`define SCRCB_GP0_IDX         3'h0
`define SCRCB_GP1_IDX         3'h1
`define SCRCB_GP2_IDX         3'h2
`define SCRCB_GP3_IDX         3'h3
`define SCRCB_CFG_IDX         3'h4
`define SCRCB_ADDR_W          5

// ==========================================================
// serdes_clock_config fields
`define SCRCB_CFG_W           16
`define SCRCB_CFG_RESET       16'h0000
`define SCRCB_CFG_WMASK       16'h80BB
`define SCRCB_BIT_RST_N       15
`define SCRCB_BIT_OSC1_EN     7
`define SCRCB_BIT_Q1_SEL      5
`define SCRCB_BIT_Q1_MUX      4
`define SCRCB_BIT_OSC0_EN     3
`define SCRCB_BIT_Q0_SEL      1
`define SCRCB_BIT_Q0_MUX      0

// ==========================================================
// general purpose registers
`define SCRCB_GP_W            32
`define SCRCB_GP_RESET        32'h00000000

`endif

// ==== verif/scrcb_bank_monitor.sv ====
// Purpose: port-level checks of the clock config bank
// Assumes: zero-wait APB, cfg at byte 0x10
// Notes:   bound to every scrcb_bank
`timescale 1ns/10ps
module scrcb_bank_monitor (
  input wire        sys_clk,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [4:0]  paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire        pready,
  input wire        pslverr,
  input wire        serdes_rst_n,
  input wire        quad1_local_oscillator_en,
  input wire        quad0_local_oscillator_en,
  input wire        quad1_use_local,
  input wire        quad1_use_external_refclk_one,
  input wire        quad0_use_external_refclk_one
);
  // ====
  // checks
  wire cw = psel & penable & pwrite & (paddr[4:2] == 3'h4);
  wire lo = cw & pstrb[0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_cfg_wr;
    psel && !penable && pwrite && paddr[4:2] == 3'h4 ##1 penable && pstrb[1];
  endsequence
  a_rst_write: assert property (s_cfg_wr |=>
    serdes_rst_n == $past(pwdata[15])) else $error("bit 15 lost");
  a_osc_one: assert property (lo |=>
    quad1_local_oscillator_en == $past(pwdata[7])) else $error("bit 7 lost");
  a_osc_zero: assert property (lo |=>
    quad0_local_oscillator_en == $past(pwdata[3])) else $error("bit 3 lost");
  a_q1_mux: assert property (lo |=> quad1_use_external_refclk_one ==
    $past(pwdata[5] & pwdata[4])) else $error("quad 1 mux");
  a_q0_mux: assert property (lo |=> quad0_use_external_refclk_one ==
    $past(pwdata[1] & pwdata[0])) else $error("quad 0 mux");
  a_cfg_hold: assert property (!cw |=> $stable(serdes_rst_n) &&
    $stable(quad1_use_local)) else $error("cfg changed");
  a_bus_answer: assert property (psel && penable |-> pready &&
    pslverr == (paddr[4:2] > 3'h4)) else $error("bad answer");
  a_reset_zero: assert property (disable iff (1'b0) rst |=>
    !serdes_rst_n && quad1_use_local) else $error("reset value");
endmodule
bind scrcb_bank scrcb_bank_monitor u_mon (.*);

// ==== verif/scrcb_bank_tb.sv ====
// Purpose: register-level test of the clock config bank
// Assumes: zero-wait APB slave, 25 MHz sys_clk
// Notes:   expected values come from field positions only
`timescale 1ns/10ps
module scrcb_bank_tb;
  localparam [111:0] TV = {16'h8080, 16'h8030, 16'h8020, 16'h0010,
    16'h808A, 16'h8009, 16'h0022};
  reg         sys_clk, rst, psel, penable, pwrite, e;
  reg  [4:0]  paddr;
  reg  [31:0] pwdata, r;
  reg  [3:0]  pstrb;
  wire        pready, pslverr, serdes_rst_n, clk_ok;
  wire        quad1_local_oscillator_en, quad0_local_oscillator_en;
  wire        quad1_use_local, quad1_use_external_refclk_zero;
  wire        quad1_use_external_refclk_one, quad1_local_invalid;
  wire        quad0_use_local, quad0_use_external_refclk_zero;
  wire        quad0_use_external_refclk_one, quad0_local_invalid;
  wire [31:0] prdata;
  integer     mismatches, n_compared, i;
  wire [11:0] ob = {clk_ok, serdes_rst_n, quad1_local_oscillator_en,
    quad0_local_oscillator_en, quad1_use_local, quad1_use_external_refclk_zero,
    quad1_use_external_refclk_one, quad1_local_invalid, quad0_use_local,
    quad0_use_external_refclk_zero, quad0_use_external_refclk_one,
    quad0_local_invalid};
  scrcb_bank u_dut (.*);
  scrcb_refclk_model u_far (.serdes_rst_n(serdes_rst_n),
    .osc_en(quad1_local_oscillator_en), .use_local(quad1_use_local),
    .use_ext(quad1_use_external_refclk_zero | quad1_use_external_refclk_one),
    .clk_ok(clk_ok));
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ====
  // bus and compare tasks
  task xfer(input w, input [4:0] a, input [31:0] d, input [3:0] s);
    integer n;
    begin
      @(posedge sys_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge sys_clk);
      penable <= 1;
      n = 0;
      @(posedge sys_clk);
      while (pready !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge sys_clk);
      end
      // a slave that never answers is a failure, not a silent pass
      if (n >= 50) begin
        mismatches = mismatches + 1;
        $display("MISMATCH pready exp 1 got %b", pready);
      end
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      // let the edge's register updates land before outputs are compared
      #1;
    end
  endtask
  task chk(input string nm, input [31:0] x, input [31:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== x) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %s exp %h got %h", nm, x, g);
      end
    end
  endtask
  function [11:0] eo(input [15:0] v);
    eo = {v[15] & (v[5] | v[7]), v[15], v[7], v[3], !v[5], v[5] & !v[4],
      v[5] & v[4], !v[5] & !v[7], !v[1], v[1] & !v[0], v[1] & v[0],
      !v[1] & !v[3]};
  endfunction
  task wrap_up;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    #80000;
    mismatches = mismatches + 1;
    wrap_up;
  end
  // ====
  // test sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = 0;
    rst = 1;
    mismatches = 0;
    n_compared = 0;
    repeat (12) @(posedge sys_clk);
    rst <= 0;
    xfer(0, 5'h10, 0, 4'hF);
    chk("cfg reset", 0, r);
    chk("outputs", eo(0), ob);
    xfer(1, 5'h10, 32'hFFFFFFFF, 4'hF);
    xfer(0, 5'h10, 0, 4'hF);
    chk("reserved", 32'h80BB, r);
    for (i = 0; i < 7; i = i + 1) begin
      xfer(1, 5'h10, TV[i*16 +: 16], 4'hF);
      chk("decode", eo(TV[i*16 +: 16]), ob);
    end
    for (i = 0; i < 4; i = i + 1)
      xfer(1, {i[2:0], 2'b00}, 32'h5A5A0000 | i, 4'hF);
    for (i = 0; i < 4; i = i + 1) begin
      xfer(0, {i[2:0], 2'b00}, 0, 4'hF);
      chk("gp", 32'h5A5A0000 | i, r);
    end
    xfer(1, 5'h14, 32'hFFFFFFFF, 4'hF);
    chk("slverr", 1, e);
    xfer(0, 5'h1C, 0, 4'hF);
    chk("unmapped", 0, r);
    xfer(1, 5'h10, 0, 4'hF);
    xfer(1, 5'h10, 32'h8080, 4'h1);
    xfer(0, 5'h10, 0, 4'hF);
    chk("lanes", 32'h0080, r);
    xfer(1, 5'h10, 32'h8080, 4'hF);
    @(posedge sys_clk);
    rst <= 1;
    @(posedge sys_clk);
    rst <= 0;
    #1;
    chk("rerst", eo(0), ob);
    wrap_up;
  end
endmodule

// ==== verif/scrcb_refclk_model.sv ====
// Purpose: far-side model of quad 1 reference clocking
// Assumes: both connector clocks are present and running
// Notes:   reports whether quad 1 sees a usable refclk
`timescale 1ns/10ps
module scrcb_refclk_model (
  input  wire serdes_rst_n,
  input  wire osc_en,
  input  wire use_local,
  input  wire use_ext,
  output wire clk_ok
);
  // ====
  // clock check
  // quad needs release
  assign clk_ok = serdes_rst_n & (use_local ? osc_en : use_ext);
endmodule
